// file: shared/psr_pkg.sv
// package: register map, field layout, reset values and carriers of the shadow readback block
package psr_pkg;
  localparam int unsigned PSR_NUM_CH = 6;
  localparam int unsigned PSR_NUM_CAPT = 4;
  localparam logic [7:0] PSR_ADDR_CONTROL = 8'h00;
  localparam logic [7:0] PSR_ADDR_PERIOD = 8'h04;
  localparam logic [7:0] PSR_ADDR_PRESCALE = 8'h08;
  localparam logic [7:0] PSR_ADDR_DELAY = 8'h0C;
  localparam logic [7:0] PSR_ADDR_ACT_BASE = 8'h10;
  localparam logic [7:0] PSR_ADDR_DEACT_BASE = 8'h28;
  localparam logic [7:0] PSR_ADDR_GEN_STAT = 8'h40;
  localparam logic [7:0] PSR_ADDR_GEN_MASK = 8'h44;
  localparam logic [7:0] PSR_ADDR_MATCH_STAT = 8'h48;
  localparam logic [7:0] PSR_ADDR_MATCH_MASK = 8'h4C;
  localparam logic [7:0] PSR_ADDR_CAPT_STAT = 8'h50;
  localparam logic [7:0] PSR_ADDR_CAPT_MASK = 8'h54;
  // control mirror field positions
  localparam int unsigned PSR_BURST_LSB = 16;
  localparam int unsigned PSR_LEVEL_LSB = 0;
  // interrupt bit positions and status register widths
  localparam int unsigned PSR_GEN_WRAP = 0;
  localparam int unsigned PSR_GEN_XFER = 1;
  localparam int unsigned PSR_GEN_UPD = 2;
  localparam int unsigned PSR_GEN_TRAP = 3;
  localparam int unsigned PSR_MATCH_DEACT_LSB = 6;
  localparam int unsigned PSR_GEN_W = 4;
  localparam int unsigned PSR_MATCH_W = 12;
  localparam int unsigned PSR_CAPT_W = 4;
  // reset values
  localparam logic [5:0] PSR_RST_BURST = 6'h00;
  localparam logic [5:0] PSR_RST_LEVEL = 6'h3F;
  localparam logic [15:0] PSR_RST_PERIOD = 16'hFFFF;
  localparam logic [15:0] PSR_RST_PRESCALE = 16'hFFFF;
  localparam logic [15:0] PSR_RST_DELAY = 16'h0000;
  localparam logic [15:0] PSR_RST_MATCH = 16'h0000;
  localparam logic [3:0] PSR_RST_GEN_MASK = 4'h0;
  localparam logic [11:0] PSR_RST_MATCH_MASK = 12'h000;
  localparam logic [3:0] PSR_RST_CAPT_MASK = 4'h0;

  // values in use in the pwm domain
  typedef struct packed {
    logic [5:0] burst_enable_mirror;
    logic [5:0] active_level_mirror;
    logic [15:0] period_value_mirror;
    logic [15:0] prescale_value_mirror;
    logic [15:0] delay_value_mirror;
    logic [PSR_NUM_CH-1:0][15:0] activation_value_mirror;
    logic [PSR_NUM_CH-1:0][15:0] deactivation_value_mirror;
  } psr_shadow_t;

  // one-cycle event pulses from the pwm core
  typedef struct packed {
    logic trap_emergency_flag;
    logic update_done_flag;
    logic transfer_done_flag;
    logic wrap_flag;
    logic [PSR_NUM_CH-1:0] deactivation_hit;
    logic [PSR_NUM_CH-1:0] activation_hit;
    logic [PSR_NUM_CAPT-1:0] capture_hit;
  } psr_events_t;
endpackage

// file: src/psr_shadow_readback.sv
// shadow readback registers and interrupt sources of a pwm unit, apb slave
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
// Notes on behaviour
// - shadow registers are read-only and show values the pwm core uses
// - control mirror: burst enable bits 21..16 reset 00h, level bits 5..0 reset 3Fh
// - period mirror bits 15..0, reset FFFFh
// - prescale mirror bits 15..0, reset FFFFh
// - sync delay mirror bits 15..0, reset 0000h
// - six activation match mirrors, bits 15..0, reset 0000h
// - six deactivation match mirrors, bits 15..0, reset 0000h
// - reserved bits of the mirrors read as zero
// - two active-high interrupt outputs, match/capture and general
// - match/capture line from twelve matches and captures; general from the rest
// - general bits: trap 3, update 2, transfer 1, overflow 0; upper unused
// - match bits: deactivation 11..6, activation 5..0; upper unused
// - capture channels 3..0 at bits 3..0; upper unused
module psr_shadow_readback #(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire psr_pkg::psr_shadow_t in_use,
  input wire logic xfer_complete,
  input wire psr_pkg::psr_events_t events,
  output logic irq_capt_match,
  output logic irq_pwm
);

  psr_pkg::psr_shadow_t shadow_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic [psr_pkg::PSR_GEN_W-1:0] gen_stat_r;
  logic [psr_pkg::PSR_GEN_W-1:0] gen_stat_nxt;
  logic [psr_pkg::PSR_GEN_W-1:0] gen_mask_r;
  logic [psr_pkg::PSR_MATCH_W-1:0] match_stat_r;
  logic [psr_pkg::PSR_MATCH_W-1:0] match_stat_nxt;
  logic [psr_pkg::PSR_MATCH_W-1:0] match_mask_r;
  logic [psr_pkg::PSR_CAPT_W-1:0] capt_stat_r;
  logic [psr_pkg::PSR_CAPT_W-1:0] capt_stat_nxt;
  logic [psr_pkg::PSR_CAPT_W-1:0] capt_mask_r;
  logic [psr_pkg::PSR_GEN_W-1:0] gen_set;
  logic [psr_pkg::PSR_MATCH_W-1:0] match_set;
  logic [7:0] addr8;
  logic setup_phase;
  logic acc_rd;
  logic acc_wr;
  logic [31:0] rd_mux;
  logic rd_err;
  logic wr_err;

  // apb phase decode
  assign addr8 = 8'(paddr);
  assign setup_phase = psel && !penable;
  assign acc_rd = psel && penable && !pwrite;
  assign acc_wr = psel && penable && pwrite;
  assign pready = 1'b1;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;

  // shadow copy follows the pwm domain only at transfer completion
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shadow_r.burst_enable_mirror <= psr_pkg::PSR_RST_BURST;
      shadow_r.active_level_mirror <= psr_pkg::PSR_RST_LEVEL;
      shadow_r.period_value_mirror <= psr_pkg::PSR_RST_PERIOD;
      shadow_r.prescale_value_mirror <= psr_pkg::PSR_RST_PRESCALE;
      shadow_r.delay_value_mirror <= psr_pkg::PSR_RST_DELAY;
      shadow_r.activation_value_mirror <= {psr_pkg::PSR_NUM_CH{psr_pkg::PSR_RST_MATCH}};
      shadow_r.deactivation_value_mirror <= {psr_pkg::PSR_NUM_CH{psr_pkg::PSR_RST_MATCH}};
    end else if (xfer_complete) begin
      shadow_r <= in_use;
    end
  end

  // read mux over mirrors and interrupt registers
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    unique case (addr8)
      psr_pkg::PSR_ADDR_CONTROL: begin
        rd_mux[psr_pkg::PSR_BURST_LSB +: 6] = shadow_r.burst_enable_mirror;
        rd_mux[psr_pkg::PSR_LEVEL_LSB +: 6] = shadow_r.active_level_mirror;
      end
      psr_pkg::PSR_ADDR_PERIOD: rd_mux[15:0] = shadow_r.period_value_mirror;
      psr_pkg::PSR_ADDR_PRESCALE: rd_mux[15:0] = shadow_r.prescale_value_mirror;
      psr_pkg::PSR_ADDR_DELAY: rd_mux[15:0] = shadow_r.delay_value_mirror;
      psr_pkg::PSR_ADDR_GEN_STAT: rd_mux[psr_pkg::PSR_GEN_W-1:0] = gen_stat_r;
      psr_pkg::PSR_ADDR_GEN_MASK: rd_mux[psr_pkg::PSR_GEN_W-1:0] = gen_mask_r;
      psr_pkg::PSR_ADDR_MATCH_STAT: rd_mux[psr_pkg::PSR_MATCH_W-1:0] = match_stat_r;
      psr_pkg::PSR_ADDR_MATCH_MASK: rd_mux[psr_pkg::PSR_MATCH_W-1:0] = match_mask_r;
      psr_pkg::PSR_ADDR_CAPT_STAT: rd_mux[psr_pkg::PSR_CAPT_W-1:0] = capt_stat_r;
      psr_pkg::PSR_ADDR_CAPT_MASK: rd_mux[psr_pkg::PSR_CAPT_W-1:0] = capt_mask_r;
      default: begin
        rd_err = 1'b1;
        for (int i = 0; i < psr_pkg::PSR_NUM_CH; i++) begin
          if (addr8 == 8'(psr_pkg::PSR_ADDR_ACT_BASE + 8'(4 * i))) begin
            rd_mux[15:0] = shadow_r.activation_value_mirror[i];
            rd_err = 1'b0;
          end
          if (addr8 == 8'(psr_pkg::PSR_ADDR_DEACT_BASE + 8'(4 * i))) begin
            rd_mux[15:0] = shadow_r.deactivation_value_mirror[i];
            rd_err = 1'b0;
          end
        end
      end
    endcase
  end

  // only the mask registers take writes; mirrors refuse them
  assign wr_err = !(addr8 == psr_pkg::PSR_ADDR_GEN_MASK ||
                    addr8 == psr_pkg::PSR_ADDR_MATCH_MASK ||
                    addr8 == psr_pkg::PSR_ADDR_CAPT_MASK);

  // read data and error captured in the setup cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup_phase) begin
      prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_r <= pwrite ? wr_err : rd_err;
    end
  end

  // mask registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gen_mask_r <= psr_pkg::PSR_RST_GEN_MASK;
      match_mask_r <= psr_pkg::PSR_RST_MATCH_MASK;
      capt_mask_r <= psr_pkg::PSR_RST_CAPT_MASK;
    end else if (acc_wr) begin
      if (addr8 == psr_pkg::PSR_ADDR_GEN_MASK) begin
        gen_mask_r <= pwdata[psr_pkg::PSR_GEN_W-1:0];
      end
      if (addr8 == psr_pkg::PSR_ADDR_MATCH_MASK) begin
        match_mask_r <= pwdata[psr_pkg::PSR_MATCH_W-1:0];
      end
      if (addr8 == psr_pkg::PSR_ADDR_CAPT_MASK) begin
        capt_mask_r <= pwdata[psr_pkg::PSR_CAPT_W-1:0];
      end
    end
  end

  // event bit placement
  always_comb begin
    gen_set = '0;
    gen_set[psr_pkg::PSR_GEN_TRAP] = events.trap_emergency_flag;
    gen_set[psr_pkg::PSR_GEN_UPD] = events.update_done_flag;
    gen_set[psr_pkg::PSR_GEN_XFER] = events.transfer_done_flag;
    gen_set[psr_pkg::PSR_GEN_WRAP] = events.wrap_flag;
    match_set = {events.deactivation_hit, events.activation_hit};
  end

  // sticky status: a read clears only the bits it returned, a new event wins
  always_comb begin
    gen_stat_nxt = gen_stat_r;
    match_stat_nxt = match_stat_r;
    capt_stat_nxt = capt_stat_r;
    if (acc_rd && addr8 == psr_pkg::PSR_ADDR_GEN_STAT) begin
      gen_stat_nxt = gen_stat_r & ~prdata_r[psr_pkg::PSR_GEN_W-1:0];
    end
    if (acc_rd && addr8 == psr_pkg::PSR_ADDR_MATCH_STAT) begin
      match_stat_nxt = match_stat_r & ~prdata_r[psr_pkg::PSR_MATCH_W-1:0];
    end
    if (acc_rd && addr8 == psr_pkg::PSR_ADDR_CAPT_STAT) begin
      capt_stat_nxt = capt_stat_r & ~prdata_r[psr_pkg::PSR_CAPT_W-1:0];
    end
    gen_stat_nxt = gen_stat_nxt | gen_set;
    match_stat_nxt = match_stat_nxt | match_set;
    capt_stat_nxt = capt_stat_nxt | events.capture_hit;
  end

  // status registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gen_stat_r <= '0;
      match_stat_r <= '0;
      capt_stat_r <= '0;
    end else begin
      gen_stat_r <= gen_stat_nxt;
      match_stat_r <= match_stat_nxt;
      capt_stat_r <= capt_stat_nxt;
    end
  end

  // two level request lines
  assign irq_capt_match = |(match_stat_r & match_mask_r) |
                          |(capt_stat_r & capt_mask_r);
  assign irq_pwm = |(gen_stat_r & gen_mask_r);

  sequence read_setup_s(logic [7:0] a);
    psel && !penable && !pwrite && addr8 == a;
  endsequence

  sequence read_access_s(logic [7:0] a);
    psel && penable && !pwrite && addr8 == a;
  endsequence

  sequence write_setup_s(logic [7:0] a);
    psel && !penable && pwrite && addr8 == a;
  endsequence

  shadow_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    !xfer_complete |=> $stable(shadow_r))
    else $error("mirror changed without transfer completion");

  shadow_load_a: assert property (@(posedge clk) disable iff (!rstn)
    xfer_complete |=> shadow_r == $past(in_use))
    else $error("mirror did not take value in use");

  ctrl_read_a: assert property (@(posedge clk) disable iff (!rstn)
    read_setup_s(psr_pkg::PSR_ADDR_CONTROL) |=>
      prdata[21:16] == $past(shadow_r.burst_enable_mirror) &&
      prdata[5:0] == $past(shadow_r.active_level_mirror))
    else $error("control mirror readback wrong");

  period_read_a: assert property (@(posedge clk) disable iff (!rstn)
    read_setup_s(psr_pkg::PSR_ADDR_PERIOD) |=>
      prdata == {16'h0000, $past(shadow_r.period_value_mirror)})
    else $error("period mirror readback wrong");

  reserved_zero_a: assert property (@(posedge clk) disable iff (!rstn)
    read_setup_s(psr_pkg::PSR_ADDR_CONTROL) |=>
      prdata[31:22] == 10'h000 && prdata[15:6] == 10'h000)
    else $error("reserved control bits not zero");

  act_read_a: assert property (@(posedge clk) disable iff (!rstn)
    read_setup_s(psr_pkg::PSR_ADDR_ACT_BASE) |=>
      prdata == {16'h0000, $past(shadow_r.activation_value_mirror[0])})
    else $error("activation mirror readback wrong");

  trap_bit_a: assert property (@(posedge clk) disable iff (!rstn)
    events.trap_emergency_flag |=> gen_stat_r[3])
    else $error("trap event not at bit 3");

  deact_bit_a: assert property (@(posedge clk) disable iff (!rstn)
    events.deactivation_hit[5] |=> match_stat_r[11])
    else $error("deactivation ch5 not at bit 11");

  capt_bit_a: assert property (@(posedge clk) disable iff (!rstn)
    events.capture_hit[3] |=> capt_stat_r[3])
    else $error("capture ch3 not at bit 3");

  gen_irq_a: assert property (@(posedge clk) disable iff (!rstn)
    events.wrap_flag && gen_mask_r[0] && !acc_wr |=> irq_pwm ##1 (irq_pwm ||
      $past(acc_rd && addr8 == psr_pkg::PSR_ADDR_GEN_STAT || acc_wr)))
    else $error("general request not held");

  match_irq_a: assert property (@(posedge clk) disable iff (!rstn)
    events.activation_hit[0] && match_mask_r[0] && !acc_wr |=> irq_capt_match)
    else $error("match request missing");

  read_clear_a: assert property (@(posedge clk) disable iff (!rstn)
    read_access_s(psr_pkg::PSR_ADDR_GEN_STAT) ##0 !(|gen_set) |=>
      (gen_stat_r & $past(prdata[psr_pkg::PSR_GEN_W-1:0])) == '0)
    else $error("status not cleared by read");

  // prescale, delay and the first and last channel mirrors, whole word so reserved bits are covered too
  prescale_read_a: assert property (@(posedge clk) disable iff (!rstn)
    read_setup_s(psr_pkg::PSR_ADDR_PRESCALE) |=>
      prdata == {16'h0000, $past(shadow_r.prescale_value_mirror)})
    else $error("prescale mirror readback wrong");

  delay_read_a: assert property (@(posedge clk) disable iff (!rstn)
    read_setup_s(psr_pkg::PSR_ADDR_DELAY) |=>
      prdata == {16'h0000, $past(shadow_r.delay_value_mirror)})
    else $error("delay mirror readback wrong");

  // channel 5 sits 14h above the base
  act_last_a: assert property (@(posedge clk) disable iff (!rstn)
    read_setup_s(8'(psr_pkg::PSR_ADDR_ACT_BASE + 8'h14)) |=>
      prdata == {16'h0000, $past(shadow_r.activation_value_mirror[5])})
    else $error("activation ch5 mirror readback wrong");

  deact_read_a: assert property (@(posedge clk) disable iff (!rstn)
    read_setup_s(psr_pkg::PSR_ADDR_DEACT_BASE) |=>
      prdata == {16'h0000, $past(shadow_r.deactivation_value_mirror[0])})
    else $error("deactivation mirror readback wrong");

  deact_last_a: assert property (@(posedge clk) disable iff (!rstn)
    read_setup_s(8'(psr_pkg::PSR_ADDR_DEACT_BASE + 8'h14)) |=>
      prdata == {16'h0000, $past(shadow_r.deactivation_value_mirror[5])})
    else $error("deactivation ch5 mirror readback wrong");

  // unused upper bits of the interrupt registers
  gen_upper_a: assert property (@(posedge clk) disable iff (!rstn)
    read_setup_s(psr_pkg::PSR_ADDR_GEN_STAT) |=>
      prdata[31:4] == 28'h0000000)
    else $error("general status upper bits not zero");

  match_upper_a: assert property (@(posedge clk) disable iff (!rstn)
    read_setup_s(psr_pkg::PSR_ADDR_MATCH_STAT) |=>
      prdata[31:12] == 20'h00000)
    else $error("match status upper bits not zero");

  capt_upper_a: assert property (@(posedge clk) disable iff (!rstn)
    read_setup_s(psr_pkg::PSR_ADDR_CAPT_STAT) |=>
      prdata[31:4] == 28'h0000000)
    else $error("capture status upper bits not zero");

  // placement of the other event sources, and the capture request
  wrap_bit_a: assert property (@(posedge clk) disable iff (!rstn)
    events.wrap_flag |=> gen_stat_r[0])
    else $error("overflow event not at bit 0");

  xfer_bit_a: assert property (@(posedge clk) disable iff (!rstn)
    events.transfer_done_flag |=> gen_stat_r[1])
    else $error("transfer event not at bit 1");

  upd_bit_a: assert property (@(posedge clk) disable iff (!rstn)
    events.update_done_flag |=> gen_stat_r[2])
    else $error("update event not at bit 2");

  act_bit_a: assert property (@(posedge clk) disable iff (!rstn)
    events.activation_hit[0] |=> match_stat_r[0])
    else $error("activation ch0 not at bit 0");

  capt_irq_a: assert property (@(posedge clk) disable iff (!rstn)
    events.capture_hit[0] && capt_mask_r[0] && !acc_wr |=> irq_capt_match)
    else $error("capture request missing");

  // refusal, stickiness and mask update
  mirror_refuse_a: assert property (@(posedge clk) disable iff (!rstn)
    write_setup_s(psr_pkg::PSR_ADDR_PERIOD) |=> pslverr)
    else $error("mirror write not refused");

  stat_keep_a: assert property (@(posedge clk) disable iff (!rstn)
    gen_stat_r[3] && !acc_rd |=> gen_stat_r[3])
    else $error("status bit lost without a read");

  mask_write_a: assert property (@(posedge clk) disable iff (!rstn)
    acc_wr && addr8 == psr_pkg::PSR_ADDR_GEN_MASK |=>
      gen_mask_r == $past(pwdata[psr_pkg::PSR_GEN_W-1:0]))
    else $error("general mask write lost");

endmodule // psr_shadow_readback

// file: tb/psr_vic_model.sv
// interrupt controller stand-in that samples both request lines
`timescale 1ns/10ps
module psr_vic_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic irq_capt_match,
  input wire logic irq_pwm,
  output logic [1:0] pend
);
  // level requests taken once per clock
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend <= 2'b00;
    end else begin
      pend <= {irq_capt_match, irq_pwm};
    end
  end
endmodule // psr_vic_model

// file: tb/pwm_shadow_readback_irq_tb_top.sv
// self-checking bench for the shadow readback and interrupt block
`timescale 1ns/10ps
module pwm_shadow_readback_irq_tb_top;
  typedef struct packed {logic [7:0] a; logic [31:0] d;} psr_row_t;
  logic clk, rstn, psel, penable, pwrite, xfer_complete, pready, pslverr, err;
  logic irq_capt_match, irq_pwm;
  logic [7:0] paddr, sa;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] pend;
  logic [19:0] ev;
  int eb;
  psr_pkg::psr_shadow_t in_use, nv;
  psr_row_t rows [22];
  int failures, checked;

  psr_shadow_readback i_dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .in_use(in_use), .xfer_complete(xfer_complete), .events(ev),
    .irq_capt_match(irq_capt_match), .irq_pwm(irq_pwm));
  psr_vic_model i_vic (.clk(clk), .rstn(rstn), .irq_capt_match(irq_capt_match),
    .irq_pwm(irq_pwm), .pend(pend));

  // clock generator
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  // one apb transfer, setup then access until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    chk("prdata", e, rd);
    chk("pslverr", {31'h0, ee}, {31'h0, err});
  endtask

  task automatic run_rows(input int n);
    for (int r = 0; r < n; r++) begin
      rchk(rows[r].a, rows[r].d, 1'b0);
    end
  endtask

  task automatic summarize;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    #80000;
    failures++;
    summarize();
  end

  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata, xfer_complete, ev} = '0;
    in_use = '0;
    failures = 0;
    checked = 0;
    rows[0] = '{psr_pkg::PSR_ADDR_CONTROL, 32'h0000003F};
    rows[1] = '{psr_pkg::PSR_ADDR_PERIOD, 32'h0000FFFF};
    rows[2] = '{psr_pkg::PSR_ADDR_PRESCALE, 32'h0000FFFF};
    rows[3] = '{psr_pkg::PSR_ADDR_DELAY, 32'h0};
    for (int c = 0; c < 6; c++) begin
      rows[4 + c] = '{psr_pkg::PSR_ADDR_ACT_BASE + 8'(4 * c), 32'h0};
      rows[10 + c] = '{psr_pkg::PSR_ADDR_DEACT_BASE + 8'(4 * c), 32'h0};
    end
    for (int k = 0; k < 6; k++) begin
      rows[16 + k] = '{psr_pkg::PSR_ADDR_GEN_STAT + 8'(4 * k), 32'h0};
    end
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    run_rows(22);
    nv = '1;
    nv.burst_enable_mirror = 6'h2A;
    nv.active_level_mirror = 6'h15;
    nv.period_value_mirror = 16'h1234;
    nv.delay_value_mirror = 16'h0F0F;
    @(posedge clk);
    in_use <= nv;
    rchk(psr_pkg::PSR_ADDR_CONTROL, 32'h0000003F, 1'b0);
    @(posedge clk);
    xfer_complete <= 1'b1;
    @(posedge clk);
    xfer_complete <= 1'b0;
    in_use <= '0;
    rows[0].d = 32'h002A0015;
    rows[1].d = 32'h00001234;
    rows[2].d = 32'h0000FFFF;
    rows[3].d = 32'h00000F0F;
    for (int r = 4; r < 16; r++) rows[r].d = 32'h0000FFFF;
    run_rows(16);
    apb(1'b1, psr_pkg::PSR_ADDR_PERIOD, 32'h0);
    chk("wr_err", 32'h1, {31'h0, err});
    rchk(psr_pkg::PSR_ADDR_PERIOD, 32'h00001234, 1'b0);
    rchk(8'h60, 32'h0, 1'b1);
    apb(1'b1, psr_pkg::PSR_ADDR_GEN_STAT, 32'hF);
    chk("stat_wr_err", 32'h1, {31'h0, err});
    apb(1'b1, psr_pkg::PSR_ADDR_GEN_MASK, 32'hF);
    apb(1'b1, psr_pkg::PSR_ADDR_MATCH_MASK, 32'hFFF);
    apb(1'b1, psr_pkg::PSR_ADDR_CAPT_MASK, 32'hF);
    chk("mask_wr_err", 32'h0, {31'h0, err});
    rchk(psr_pkg::PSR_ADDR_MATCH_MASK, 32'h00000FFF, 1'b0);
    // every event source, one at a time
    for (int i = 0; i < 20; i++) begin
      sa = i >= 16 ? psr_pkg::PSR_ADDR_GEN_STAT
         : i >= 4 ? psr_pkg::PSR_ADDR_MATCH_STAT : psr_pkg::PSR_ADDR_CAPT_STAT;
      eb = i >= 16 ? i - 16 : i >= 4 ? i - 4 : i;
      @(posedge clk);
      ev <= 20'h1 << i;
      @(posedge clk);
      ev <= '0;
      @(negedge clk);
      chk("irq_pwm", 32'(i >= 16), {31'h0, irq_pwm});
      chk("irq_capt_match", 32'(i < 16), {31'h0, irq_capt_match});
      @(negedge clk);
      chk("vic_pend", {30'h0, i < 16, i >= 16}, {30'h0, pend});
      rchk(sa, 32'h1 << eb, 1'b0);
      rchk(sa, 32'h0, 1'b0);
      @(negedge clk);
      chk("irq_idle", 32'h0, {30'h0, irq_capt_match, irq_pwm});
    end
    // masked-off event keeps the line low yet sets status
    apb(1'b1, psr_pkg::PSR_ADDR_GEN_MASK, 32'h7);
    @(posedge clk);
    ev <= 20'h80000;
    @(posedge clk);
    ev <= '0;
    @(negedge clk);
    chk("irq_masked", 32'h0, {31'h0, irq_pwm});
    rchk(psr_pkg::PSR_ADDR_GEN_STAT, 32'h8, 1'b0);
    // event on the setup edge, then on the access edge, of a status read
    for (int s = 1; s < 3; s++) begin
      fork
        apb(1'b0, psr_pkg::PSR_ADDR_GEN_STAT, 32'h0);
        begin
          repeat (s) @(posedge clk);
          ev <= 20'h10000;
          @(posedge clk);
          ev <= '0;
        end
      join
      chk("stat_race_rd", 32'h0, rd);
      rchk(psr_pkg::PSR_ADDR_GEN_STAT, 32'h1, 1'b0);
    end
    // second reset in mid-run restores mirrors
    @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rchk(psr_pkg::PSR_ADDR_CONTROL, 32'h0000003F, 1'b0);
    rchk(psr_pkg::PSR_ADDR_GEN_MASK, 32'h0, 1'b0);
    summarize();
  end
endmodule // pwm_shadow_readback_irq_tb_top
